// ==== core/isfm_monitor.sv ====
/*
 File: logic-side fault monitor of a four-channel isolated switch:
 open-load warnings, link watchdog with output shutdown, state indicators.
 Assumes: control and analog status arrive as pins; link heartbeat pulses
 come from the link receiver on core_clk; the serial port sits outside and
 reads the fault registers and drives the clear request.
*/
// Function
// - Open-load warning only while channel input low
// - Open load sets warning bit and indicator
// - All channels on: warnings zero, indicator inactive
// - Channel one uses enable bit zero
// - Control inputs bypass the diagnostic link
// - Link watchdog sets fault flag, shuts switches
// - Link fault disables outputs until clear, gone
// - Dead switch side sets flag, disables outputs
// - Switch side alone disables without logic side
// - One open-drain low indicator per channel
// - Indicator mirrors actual switch state bit
// - Over-current off clears state, indicator follows
// - Registers exposed for serial master access
// - Chain up to thirty-two addressable devices
// - Link fault in summary bit seven
// - Channel one open warning bit zero
module isfm_monitor #(
    parameter int NCH         = isfm_pkg::NUM_CHANNELS,
    parameter int TIMEOUT_CYC = isfm_pkg::LINK_TIMEOUT_CYC,
    parameter int CHAIN_LEN   = isfm_pkg::MAX_CHAIN
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic           clkEn,
    input  wire logic [NCH-1:0] channelControlInput,
    input  wire logic [NCH-1:0] openLoadDetect,
    input  wire logic [NCH-1:0] switchOnSense,
    input  wire logic           linkHeartbeat,
    input  wire logic           linkCrcError,
    input  wire logic           switchSidePowerGood,
    input  wire logic           clearLinkFault,
    input  wire logic [4:0]     chainAddress,
    output logic [NCH-1:0]      switchEnableBits,
    output logic [NCH-1:0]      switchStateBits,
    output logic [7:0]          summaryFaultRegister,
    output logic [7:0]          channelFaultRegister21,
    output logic [7:0]          channelFaultRegister43,
    output logic [NCH-1:0]      openLoadWarning,
    output logic                openLoadIndicator_n_o,
    output logic                openLoadIndicator_n_oe,
    output logic [NCH-1:0]      stateIndicator_n_o,
    output logic [NCH-1:0]      stateIndicator_n_oe,
    output logic [4:0]          deviceAddress
);
    typedef enum logic [1:0] {ISFM_LINK_OK, ISFM_LINK_FAULT, ISFM_LINK_WAITCLR} isfm_link_t;

    // Elaboration check: register images fix four channels, strap fixes chain depth
    if (NCH != 4 || TIMEOUT_CYC < 1 || CHAIN_LEN < 1 || CHAIN_LEN > 32)
    begin : gBadParams
        $error("isfm_monitor: unsupported parameters");
    end

    localparam int CW = $clog2(TIMEOUT_CYC + 1); // Watchdog counter width

    // Pin synchronisers for control, load and sense pins
    isfm_sync_if #(.W(3*NCH+1)) pinIf ();
    // Power-good enters inverted: the chain's reset level then reads as alive,
    // so reset release raises no false link fault
    assign pinIf.raw = {~switchSidePowerGood, switchOnSense, openLoadDetect,
                        channelControlInput};
    isfm_pin_sync #(.W(3*NCH+1)) uSync (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .sp       (pinIf)
    );

    logic [NCH-1:0] ctrlIn;       // Synchronised channel inputs
    logic [NCH-1:0] openIn;       // Synchronised open-load comparators
    logic [NCH-1:0] senseIn;      // Synchronised actual switch state
    logic           powerGood;    // Synchronised switch-side power
    assign ctrlIn    = pinIf.clean[NCH-1:0];
    assign openIn    = pinIf.clean[2*NCH-1:NCH];
    assign senseIn   = pinIf.clean[3*NCH-1:2*NCH];
    assign powerGood = ~pinIf.clean[3*NCH];

    isfm_link_t     linkState_reg;   // Link fault state
    isfm_link_t     linkState_next;  // Next link state
    logic [CW-1:0]  wdCount_reg;     // Cycles since last heartbeat
    logic [NCH-1:0] openWarn_reg;    // Open-load warnings
    logic [NCH-1:0] state_reg;       // Switch state bits
    logic [4:0]     addr_reg;        // Chain address captured after reset
    logic           addrTaken_reg;   // Address captured once

    logic linkBad;     // Any link fault condition present
    logic linkFault;   // Flag as reported
    logic wdExpired;   // Watchdog ran out
    assign wdExpired = (wdCount_reg == CW'(TIMEOUT_CYC));
    // Loss of heartbeat, bad frame or dead switch side
    assign linkBad   = wdExpired | linkCrcError | ~powerGood;
    assign linkFault = (linkState_reg != ISFM_LINK_OK);

    // Link fault state: a clear counts only once the fault is gone
    always_comb
    begin
        case (linkState_reg)
            ISFM_LINK_OK:
                linkState_next = linkBad ? ISFM_LINK_FAULT : ISFM_LINK_OK;
            ISFM_LINK_FAULT:
                linkState_next = linkBad ? ISFM_LINK_FAULT : ISFM_LINK_WAITCLR;
            ISFM_LINK_WAITCLR:
                // Bad condition again wins over a clear
                linkState_next = linkBad ? ISFM_LINK_FAULT :
                                 (clearLinkFault ? ISFM_LINK_OK : ISFM_LINK_WAITCLR);
            default:
                linkState_next = ISFM_LINK_FAULT;
        endcase
    end

    // Watchdog counter, reset by each heartbeat
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wdCount_reg <= '0;
        else if (clkEn)
        begin
            if (linkHeartbeat)
                wdCount_reg <= '0;
            else if (!wdExpired)
                wdCount_reg <= wdCount_reg + CW'(1);
        end
    end

    // Link state register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            linkState_reg <= ISFM_LINK_OK;
        else if (clkEn)
            linkState_reg <= linkState_next;
    end

    // Warnings only for off channels; state follows actual sense
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            openWarn_reg <= '0;
            state_reg    <= '0;
        end
        else if (clkEn)
        begin
            openWarn_reg <= openIn & ~ctrlIn;
            state_reg    <= senseIn & switchEnableBits;
        end
    end

    // Chain address caught after reset release
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_reg      <= '0;
            addrTaken_reg <= 1'b0;
        end
        else if (clkEn && !addrTaken_reg)
        begin
            addr_reg      <= chainAddress;
            addrTaken_reg <= 1'b1;
        end
    end

    // Enables gated by the link fault; input bit n drives channel n
    assign switchEnableBits = linkFault ? '0 : ctrlIn;
    assign switchStateBits  = state_reg;
    assign openLoadWarning  = openWarn_reg;
    assign deviceAddress    = addr_reg;

    // Register images
    always_comb
    begin
        summaryFaultRegister = isfm_pkg::SUM_RESET;
        summaryFaultRegister[isfm_pkg::SUM_LINK_FAULT_BIT] = linkFault;
        summaryFaultRegister[NCH-1:0] = openWarn_reg;
        channelFaultRegister21 = isfm_pkg::CHF_RESET;
        channelFaultRegister43 = isfm_pkg::CHF_RESET;
        channelFaultRegister21[isfm_pkg::CH_OPEN_WARN_BIT0] = openWarn_reg[0];
        channelFaultRegister21[isfm_pkg::CH_OPEN_WARN_BIT0 + isfm_pkg::CH_FIELD_STRIDE] =
            openWarn_reg[1];
        channelFaultRegister43[isfm_pkg::CH_OPEN_WARN_BIT0] = openWarn_reg[2];
        channelFaultRegister43[isfm_pkg::CH_OPEN_WARN_BIT0 + isfm_pkg::CH_FIELD_STRIDE] =
            openWarn_reg[3];
    end

    // Open-drain low indicators: enable high pulls low
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : gInd
            assign stateIndicator_n_o[gi]  = 1'b0;
            assign stateIndicator_n_oe[gi] = state_reg[gi];
        end
    endgenerate
    assign openLoadIndicator_n_o  = 1'b0;
    assign openLoadIndicator_n_oe = |openWarn_reg;

    AST_WARN_ONLY_OFF: assert property (@(posedge core_clk) disable iff (rst)
        (openWarn_reg & $past(ctrlIn)) == '0)
        else $error("open warning on an on channel");
    AST_WARN_SET: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && openIn[0] && !ctrlIn[0] |=> channelFaultRegister21[0])
        else $error("open warning not set");
    AST_ON_INDICATOR: assert property (@(posedge core_clk) disable iff (rst)
        (ctrlIn == '1) && clkEn |=> !openLoadIndicator_n_oe)
        else $error("open indicator active with channels on");
    AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && linkBad |=> linkFault && switchEnableBits == '0)
        else $error("outputs not cut at once on link fault");
    AST_WD_TRIP: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && wdExpired && linkState_reg == ISFM_LINK_OK |=> summaryFaultRegister[7])
        else $error("watchdog expiry not flagged");
    AST_NO_POWER: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && !powerGood |=> linkFault ##0 switchEnableBits == '0)
        else $error("dead switch side not flagged");
    AST_CLEAR_HELD: assert property (@(posedge core_clk) disable iff (rst)
        linkFault && linkBad && clearLinkFault |=> linkFault)
        else $error("clear accepted during live fault");
    AST_LED_STATE: assert property (@(posedge core_clk) disable iff (rst)
        clkEn |=> stateIndicator_n_oe == ($past(senseIn) & $past(switchEnableBits)))
        else $error("indicator differs from sensed state");
    AST_ENABLE_MAP: assert property (@(posedge core_clk) disable iff (rst)
        !linkFault |-> switchEnableBits[0] == ctrlIn[0])
        else $error("channel one not on bit zero");

    COV_OPEN: cover property (@(posedge core_clk) openLoadIndicator_n_oe);
    COV_LINKRECOVER: cover property (@(posedge core_clk)
        linkState_reg == ISFM_LINK_WAITCLR ##1 linkState_reg == ISFM_LINK_OK);
    COV_OCOFF: cover property (@(posedge core_clk) switchEnableBits[0] && !state_reg[0]);
endmodule : isfm_monitor

// ==== core/isfm_pkg.sv ====
/*
 File: constants for the isolated switch fault monitor.
 Assumes: one 40 MHz core clock; all users write isfm_pkg::name.
*/
package isfm_pkg;
    localparam int NUM_CHANNELS       = 4;     // Output channels
    localparam int CLK_MHZ            = 40;    // Core clock rate
    localparam int LINK_TIMEOUT_US    = 10;    // Link silence tolerated
    localparam int LINK_TIMEOUT_CYC   = LINK_TIMEOUT_US * CLK_MHZ; // Cycles
    localparam int SUM_LINK_FAULT_BIT = 7;     // Link fault in summary reg
    localparam int CH_OPEN_WARN_BIT0  = 0;     // Channel one open-load bit
    localparam int CH_FIELD_STRIDE    = 4;     // Bits per channel in fault reg
    localparam int MAX_CHAIN          = 32;    // Daisy chain depth
    localparam logic [7:0] SUM_RESET  = 8'h00; // Summary reset value
    localparam logic [7:0] CHF_RESET  = 8'h00; // Channel fault reset value
endpackage : isfm_pkg

// ==== core/isfm_sync_if.sv ====
/*
 File: carrier of synchronised pin levels between the monitor modules.
 Assumes: one clock domain.
*/
interface isfm_sync_if #(parameter int W = 4);
    logic [W-1:0] raw;    // Raw pin levels
    logic [W-1:0] clean;  // Agreed levels
    modport syncer (input raw, output clean);
    modport user   (output raw, input clean);
endinterface : isfm_sync_if

// ==== core/isfm_pin_sync.sv ====
/*
 File: three-stage pin synchroniser; a change counts when stages two and three agree.
 Assumes: pins are asynchronous to core_clk.
*/
module isfm_pin_sync #(
    parameter int W = 4
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    isfm_sync_if.syncer sp
);
    logic [W-1:0] s1Reg;     // Metastability catcher
    logic [W-1:0] s2Reg;     // Second stage
    logic [W-1:0] s3Reg;     // Third stage
    logic [W-1:0] cleanReg;  // Accepted level
    logic [W-1:0] agree;     // Stages two and three equal

    assign agree    = ~(s2Reg ^ s3Reg);
    assign sp.clean = cleanReg;

    // Shift chain and accept agreed bits
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s1Reg    <= '0;
            s2Reg    <= '0;
            s3Reg    <= '0;
            cleanReg <= '0;
        end
        else if (clkEn)
        begin
            s1Reg    <= sp.raw;
            s2Reg    <= s1Reg;
            s3Reg    <= s2Reg;
            cleanReg <= (s3Reg & agree) | (cleanReg & ~agree);
        end
    end
endmodule : isfm_pin_sync

// ==== testbench/isfm_switch_model.sv ====
/*
 File: switch-side partner of the monitor: senses, loads, heartbeat.
 Assumes: shares core_clk and rst with the bench; bench sets fault knobs.
*/
module isfm_switch_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] enable,
    input  wire logic [3:0] overCurrent,
    input  wire logic [3:0] openLoad,
    input  wire logic       alive,
    input  wire logic       silent,
    output logic [3:0]      switchOnSense,
    output logic [3:0]      openLoadDetect,
    output logic            linkHeartbeat,
    output logic            powerGood
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] beatCnt;  // Heartbeat spacing counter
    // Output on only while enabled, powered and not over-current
    assign switchOnSense  = enable & ~overCurrent & {4{alive}};
    // Load resistance measured only while the channel is off
    assign openLoadDetect = openLoad & ~enable;
    assign powerGood      = alive;
    // Free-running spacing of heartbeat frames
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            beatCnt <= 2'h0;
        else
            beatCnt <= beatCnt + 2'h1;
    // Good frame every fourth cycle while powered and talking
    assign linkHeartbeat  = alive && !silent && (beatCnt == 2'h3);
endmodule : isfm_switch_model

// ==== testbench/isolated_switch_fault_monitor_test.sv ====
/*
 File: self-checking bench of the fault monitor against a bench model.
 Assumes: isfm_monitor with an 8-cycle watchdog; indicator pins pulled up.
*/
module isolated_switch_fault_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0;  // 40 MHz clock
    logic       rst      = 1'b1;  // Async reset
    logic [3:0] ctrl     = 4'h0;  // Channel control inputs
    logic [3:0] oc       = 4'h0;  // Over-current per channel
    logic [3:0] ol       = 4'h0;  // Open load per channel
    logic       alive    = 1'b1;  // Switch side powered
    logic       silent   = 1'b0;  // Heartbeats withheld
    logic       crc      = 1'b0;  // Link error level
    logic       clr      = 1'b0;  // Clear request
    logic [4:0] addr     = 5'h00; // Chain address strap
    logic       ce       = 1'b1;  // Clock enable
    logic       faultM   = 1'b0;  // Model link fault
    int         n_errors = 0;
    int         compares = 0;
    logic [3:0] en, sense, old, st, wrn, ledO, ledOe;
    logic       hb, pg, olO, olOe;
    logic [7:0] sum, r21, r43;
    logic [4:0] devAddr;
    wire logic       olPin  = olOe ? olO : 1'b1;            // Pulled-up open drain
    wire logic [3:0] ledPin = (ledOe & ledO) | ~ledOe;      // Pulled-up open drains
    always #12.5 core_clk = ~core_clk;
    isfm_switch_model i_sw (.core_clk(core_clk), .rst(rst), .enable(en),
        .overCurrent(oc), .openLoad(ol), .alive(alive), .silent(silent),
        .switchOnSense(sense), .openLoadDetect(old), .linkHeartbeat(hb), .powerGood(pg));
    isfm_monitor #(.TIMEOUT_CYC(8)) i_dut (.core_clk(core_clk), .rst(rst), .clkEn(ce),
        .channelControlInput(ctrl), .openLoadDetect(old), .switchOnSense(sense),
        .linkHeartbeat(hb), .linkCrcError(crc), .switchSidePowerGood(pg),
        .clearLinkFault(clr), .chainAddress(addr), .switchEnableBits(en),
        .switchStateBits(st), .summaryFaultRegister(sum), .channelFaultRegister21(r21),
        .channelFaultRegister43(r43), .openLoadWarning(wrn), .openLoadIndicator_n_o(olO),
        .openLoadIndicator_n_oe(olOe), .stateIndicator_n_o(ledO),
        .stateIndicator_n_oe(ledOe), .deviceAddress(devAddr));
    // Lets synchronisers and registers settle, ends just after an edge
    task automatic settle();
        repeat (12) @(posedge core_clk);
        #2;
    endtask : settle
    task automatic checkVal(string name, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : checkVal
    // Compares every output but deviceAddress with the bench model
    task automatic checkAll();
        logic [3:0] e;
        logic [3:0] w;
        e = faultM ? 4'h0 : ctrl;
        w = ol & ~ctrl;
        checkVal("enable", {4'h0, e}, {4'h0, en});
        checkVal("state", {4'h0, e & ~oc}, {4'h0, st});
        checkVal("warn", {4'h0, w}, {4'h0, wrn});
        checkVal("summary", {faultM, 3'h0, w}, sum);
        checkVal("ch21", {3'h0, w[1], 3'h0, w[0]}, r21);
        checkVal("ch43", {3'h0, w[3], 3'h0, w[2]}, r43);
        checkVal("olPin", {7'h0, ~|w}, {7'h0, olPin});
        checkVal("ledPin", {4'h0, ~(e & ~oc)}, {4'h0, ledPin});
    endtask : checkAll
    task automatic summarize();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // Cuts a hang short
    initial
    begin
        #(4000 * 25);
        n_errors++;
        summarize();
    end
    initial
    begin
        void'($urandom(76504));
        addr = 5'($urandom);
        repeat (4) @(posedge core_clk);
        #2;
        rst = 1'b0;
        settle();
        checkVal("address", {3'h0, addr}, {3'h0, devAddr});
        checkAll();
        $display("test reset done");
        // Random channel, load and over-current mixes
        for (int i = 0; i < 16; i++)
        begin
            ctrl = 4'($urandom);
            ol   = 4'($urandom);
            oc   = 4'($urandom);
            settle();
            checkAll();
        end
        $display("test channels done");
        // Fault kinds: switch side dead, heartbeat lost, link error
        for (int k = 0; k < 3; k++)
        begin
            ol     = 4'h0;
            ctrl   = 4'hF;
            alive  = (k != 0);
            silent = (k == 1);
            crc    = (k == 2);
            faultM = 1'b1;
            settle();
            checkAll();
            clr = 1'b1;
            settle();
            checkAll();
            clr    = 1'b0;
            alive  = 1'b1;
            silent = 1'b0;
            crc    = 1'b0;
            settle();
            checkAll();
            clr = 1'b1;
            settle();
            clr    = 1'b0;
            faultM = 1'b0;
            settle();
            checkAll();
        end
        $display("test link fault done");
        // Clock enable low: enables and warnings hold their old values
        ce   = 1'b0;
        ctrl = 4'h5;
        ol   = 4'hA;
        settle();
        checkVal("frozenEnable", 8'h0F, {4'h0, en});
        checkVal("frozenWarn", 8'h00, {4'h0, wrn});
        ce = 1'b1;
        settle();
        checkAll();
        $display("test clock enable done");
        // Reset in mid-run: outputs drop at once, link comes back up clean
        rst  = 1'b1;
        addr = 5'($urandom);
        @(posedge core_clk);
        #2;
        checkVal("resetSummary", 8'h00, sum);
        checkVal("resetState", 8'h00, {4'h0, st});
        checkVal("resetEnable", 8'h00, {4'h0, en});
        @(posedge core_clk);
        #2;
        rst = 1'b0;
        settle();
        checkVal("address", {3'h0, addr}, {3'h0, devAddr});
        checkAll();
        $display("test mid reset done");
        summarize();
    end
endmodule : isolated_switch_fault_monitor_test
